// ===== common/wdk_pkg.sv
package wdk_pkg;

  localparam int CNT_W = 19;

  // Register byte offsets
  localparam logic [7:0] OFF_WDT_CTRL  = 8'h00;
  localparam logic [7:0] OFF_SYS_FLAGS = 8'h04;
  localparam logic [7:0] OFF_STATUS    = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFF_CONFIG    = 8'h14;

  // Control register fields
  localparam int KEY_MSB = 7;
  localparam int KEY_LSB = 3;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 0;
  localparam logic [4:0] KEY_ENABLE  = 5'h0A;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [7:0] WDT_CTRL_RESET = 8'h53;

  // System flags, status, interrupt and config bit positions
  localparam int FLAG_REG_RESET = 0;
  localparam int STAT_TIMEOUT   = 0;
  localparam int STAT_PWR_DOWN  = 1;
  localparam int IRQ_OVERFLOW   = 0;
  localparam int IRQ_KEY_FAULT  = 1;
  localparam int CFG_ALWAYS     = 0;
  localparam int CFG_SRC_SUB    = 1;
  localparam logic [1:0] CFG_RESET      = 2'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Sub-clock edges between a bad key and the reset pulse
  localparam logic [1:0] FAULT_EDGES = 2'h2;
  localparam logic [1:0] DIV4_LAST   = 2'h3;

  // Timeout exponent per period code
  localparam logic [4:0] PERIOD_SHIFT [0:7] = '{
    5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12
  };

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } wdk_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wdk_apb_rsp_t;

endpackage

// ===== core/wdk_top.sv
// Behaviour
// RQ1: Control register holds key bits 7-3, period 2-0.
// RQ2: Always-enable option: either valid key runs counter.
// RQ3: Register-controlled option: 10101B disables counter.
// RQ4: Register-controlled option: 01010B enables counter.
// RQ5: Invalid key resets device after 2-3 sub-clocks; the code resets on the second sub-clock edge, 1-2 sub-clocks after the key.
// RQ6: Invalid-key reset sets register reset flag bit 0.
// RQ7: Register reset flag cleared only by software.
// RQ8: Control register resets to 01010B key, period 011.
// RQ9: Period code picks 2^8 to 2^18 source ticks.
// RQ10: Normal overflow resets device, sets timeout flag.
// RQ11: Sleep/idle overflow sets flag, resets PC/SP only.
// RQ12: Clear instruction zeroes counter; software must use it.
// RQ13: Halt instruction zeroes counter.
// RQ14: Invalid-key reset also zeroes counter.
// RQ15: Source clock is sub-clock or system clock/4.
// RQ16: Halt sets power-down flag, clears timeout flag.
// RQ17: Counter ticks while enabled, overflows at period.
module wdk_top
  import wdk_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire wdk_pkg::wdk_apb_req_t apb_req,
  output wdk_pkg::wdk_apb_rsp_t      apb_rsp,
  input  wire logic                  sub_clock,
  input  wire logic                  clear_watchdog_instruction,
  input  wire logic                  halt_instruction,
  input  wire logic                  low_power_mode,
  input  wire logic                  system_clock_stopped,
  output logic                       device_reset,
  output logic                       pc_sp_reset,
  output logic                       irq
);
  import wdk_pkg::*;

  typedef struct packed {
    logic [1:0]       sub_sync;
    logic             sub_prev;
    logic [1:0]       div4;
    logic [CNT_W-1:0] count;
    logic [7:0]       watchdog_control;
    logic             watchdog_reg_reset_flag;
    logic             timeout_flag;
    logic             power_down_flag;
    logic [1:0]       irq_status;
    logic [1:0]       irq_mask;
    logic [1:0]       config_bits;
    logic             fault_active;
    logic [1:0]       fault_edges;
    logic             device_reset;
    logic             pc_sp_reset;
    logic             irq;
    wdk_apb_rsp_t     rsp;
  } wdk_state_t;

  localparam wdk_state_t STATE_RESET = '{
    sub_sync:                2'h0,
    sub_prev:                1'b0,
    div4:                    2'h0,
    count:                   '0,
    watchdog_control:        WDT_CTRL_RESET,
    watchdog_reg_reset_flag: 1'b0,
    timeout_flag:            1'b0,
    power_down_flag:         1'b0,
    irq_status:              2'h0,
    irq_mask:                IRQ_MASK_RESET,
    config_bits:             CFG_RESET,
    fault_active:            1'b0,
    fault_edges:             2'h0,
    device_reset:            1'b0,
    pc_sp_reset:             1'b0,
    irq:                     1'b0,
    rsp:                     '0
  };

  wdk_state_t state;
  wdk_state_t next_state;

  logic [4:0]       key;
  logic [2:0]       period_code;
  logic             key_is_enable;
  logic             key_is_disable;
  logic             key_valid;
  logic             counting;
  logic             sub_tick;
  logic             sys_tick;
  logic             src_tick;
  logic [CNT_W-1:0] last_count;
  logic             overflow;
  logic             fault_fire;
  logic             access;
  logic             write_now;
  logic             mapped;
  logic [31:0]      read_data;
  logic [1:0]       irq_events;

  always_comb
  begin
    key            = state.watchdog_control[KEY_MSB:KEY_LSB]; // RQ1
    period_code    = state.watchdog_control[SEL_MSB:SEL_LSB]; // RQ1
    key_is_enable  = (key == KEY_ENABLE);
    key_is_disable = (key == KEY_DISABLE);
    key_valid      = key_is_enable || key_is_disable;
    counting       = key_is_enable // RQ2 RQ4
                     || (key_is_disable && state.config_bits[CFG_ALWAYS]); // RQ2 RQ3

    // Only the second synchroniser stage feeds the edge detector
    sub_tick = state.sub_sync[1] && !state.sub_prev;
    // System clock source dies with the system clock in deep sleep
    sys_tick = (state.div4 == DIV4_LAST) && !system_clock_stopped;
    src_tick = state.config_bits[CFG_SRC_SUB] ? sub_tick : sys_tick; // RQ15

    last_count = (CNT_W'(1) << PERIOD_SHIFT[period_code]) - CNT_W'(1); // RQ9
    overflow   = counting && src_tick && (state.count == last_count); // RQ17

    fault_fire = state.fault_active && sub_tick && (state.fault_edges == FAULT_EDGES - 2'h1);

    access    = apb_req.psel && apb_req.penable;
    write_now = access && state.rsp.pready && apb_req.pwrite;

    mapped    = 1'b1;
    read_data = '0;
    case (apb_req.paddr)
      OFF_WDT_CTRL:
      begin
        read_data[7:0] = state.watchdog_control; // RQ1
      end
      OFF_SYS_FLAGS:
      begin
        read_data[FLAG_REG_RESET] = state.watchdog_reg_reset_flag;
      end
      OFF_STATUS:
      begin
        read_data[STAT_TIMEOUT]  = state.timeout_flag;
        read_data[STAT_PWR_DOWN] = state.power_down_flag;
      end
      OFF_IRQ_STAT:
      begin
        read_data[1:0] = state.irq_status;
      end
      OFF_IRQ_MASK:
      begin
        read_data[1:0] = state.irq_mask;
      end
      OFF_CONFIG:
      begin
        read_data[1:0] = state.config_bits;
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase

    irq_events                = '0;
    irq_events[IRQ_OVERFLOW]  = overflow;
    irq_events[IRQ_KEY_FAULT] = fault_fire;
  end

  always_comb
  begin
    next_state = state;

    next_state.sub_sync = {state.sub_sync[0], sub_clock};
    next_state.sub_prev = state.sub_sync[1];
    next_state.div4     = state.div4 + 2'h1;

    // One wait state: pready rises in the second access cycle
    next_state.rsp.pready  = access && !state.rsp.pready;
    next_state.rsp.pslverr = access && !state.rsp.pready && !mapped;
    next_state.rsp.prdata  = (access && !state.rsp.pready && !apb_req.pwrite) ? read_data : '0;

    // Software writes first, so hardware events below win
    if (write_now)
    begin
      case (apb_req.paddr)
        OFF_WDT_CTRL:
        begin
          next_state.watchdog_control = apb_req.pwdata[7:0]; // RQ1
        end
        OFF_SYS_FLAGS:
        begin
          next_state.watchdog_reg_reset_flag = apb_req.pwdata[FLAG_REG_RESET]; // RQ7
        end
        OFF_IRQ_STAT:
        begin
          next_state.irq_status = state.irq_status & ~apb_req.pwdata[1:0];
        end
        OFF_IRQ_MASK:
        begin
          next_state.irq_mask = apb_req.pwdata[1:0];
        end
        OFF_CONFIG:
        begin
          next_state.config_bits = apb_req.pwdata[1:0];
        end
        default:
        begin
          next_state.irq_mask = state.irq_mask;
        end
      endcase
    end

    // Counter
    if (!counting)
    begin
      // A bad key freezes the count; the pending reset, a clear or a halt clears it
      if (key_valid)
      begin
        next_state.count = '0; // RQ3
      end
    end
    else if (src_tick)
    begin
      next_state.count = overflow ? '0 : state.count + CNT_W'(1); // RQ17
    end
    if (clear_watchdog_instruction)
    begin
      next_state.count           = '0; // RQ12
      next_state.power_down_flag = 1'b0;
    end
    if (halt_instruction)
    begin
      next_state.count           = '0; // RQ13
      next_state.power_down_flag = 1'b1; // RQ16
      next_state.timeout_flag    = 1'b0; // RQ16
    end

    // Bad key: count sub-clock edges, then reset
    if (!key_valid && !state.fault_active)
    begin
      next_state.fault_active = 1'b1; // RQ5
      next_state.fault_edges  = 2'h0;
    end
    else if (state.fault_active && sub_tick)
    begin
      next_state.fault_edges = state.fault_edges + 2'h1; // RQ5
    end

    next_state.device_reset = 1'b0;
    next_state.pc_sp_reset  = 1'b0;

    if (overflow)
    begin
      next_state.timeout_flag = 1'b1; // RQ10 RQ11
      if (low_power_mode)
      begin
        next_state.pc_sp_reset = 1'b1; // RQ11
      end
      else
      begin
        next_state.device_reset = 1'b1; // RQ10
      end
    end

    // Reload the key too, or a bad key would reset forever
    if (fault_fire)
    begin
      next_state.device_reset            = 1'b1; // RQ5
      next_state.watchdog_reg_reset_flag = 1'b1; // RQ6 RQ7
      next_state.count                   = '0; // RQ14
      next_state.watchdog_control        = WDT_CTRL_RESET;
      next_state.fault_active            = 1'b0;
      next_state.fault_edges             = 2'h0;
    end

    next_state.irq_status = next_state.irq_status | irq_events;
    next_state.irq        = |(next_state.irq_status & next_state.irq_mask);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state <= STATE_RESET; // RQ8
    end
    else
    begin
      state <= next_state;
    end
  end

  assign apb_rsp      = state.rsp;
  assign device_reset = state.device_reset;
  assign pc_sp_reset  = state.pc_sp_reset;
  assign irq          = state.irq;

endmodule

// ===== bench/wdk_top_chk.sv
module wdk_top_chk
  import wdk_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  reset,
  input wire wdk_pkg::wdk_apb_req_t apb_req,
  input wire wdk_pkg::wdk_apb_rsp_t apb_rsp,
  input wire logic                  low_power_mode,
  input wire logic                  device_reset,
  input wire logic                  pc_sp_reset,
  input wire logic                  irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  pready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held too long");
  wait_state_a: assert property ($rose(apb_req.penable) && apb_req.psel
    |-> !apb_rsp.pready ##1 apb_rsp.pready) else $error("wait state wrong");
  ready_cause_a: assert property (apb_rsp.pready
    |-> apb_req.psel && apb_req.penable && $past(apb_req.penable))
    else $error("pready outside access");
  refuse_zero_a: assert property (apb_rsp.pslverr
    |-> apb_rsp.pready && apb_rsp.prdata == 32'h0000_0000) else $error("bad refusal");
  reset_pulse_a: assert property (device_reset |=> !device_reset)
    else $error("device reset too long");
  sleep_pulse_a: assert property (pc_sp_reset |=> !pc_sp_reset)
    else $error("pc reset too long");
  sleep_cause_a: assert property (pc_sp_reset |-> $past(low_power_mode) && !device_reset)
    else $error("pc reset outside sleep");
  quiet_start_a: assert property ($fell(reset) |-> !irq && !device_reset && !pc_sp_reset)
    else $error("outputs active after reset");
endmodule

bind wdk_top wdk_top_chk chk (.clock, .reset, .apb_req, .apb_rsp, .low_power_mode,
  .device_reset, .pc_sp_reset, .irq);

// ===== bench/wdk_top_test.sv
module wdk_top_test
  import wdk_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clock = 1'b0;
  logic         reset = 1'b1;
  wdk_apb_req_t req = '0;
  wdk_apb_rsp_t rsp;
  logic [3:0]   sc_div = 4'h0;
  logic         clr = 1'b0;
  logic         halt = 1'b0;
  logic         lpm = 1'b0;
  logic         stop = 1'b0;
  logic         dev_rst;
  logic         pc_rst;
  logic         irq;
  logic [31:0]  q;
  logic         e;
  int           n_errors = 0;
  int           check_count = 0;
  int           cycles = 0;

  wdk_top uut (.clock(clock), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .sub_clock(sc_div[3]), .clear_watchdog_instruction(clr), .halt_instruction(halt),
    .low_power_mode(lpm), .system_clock_stopped(stop), .device_reset(dev_rst),
    .pc_sp_reset(pc_rst), .irq(irq));

  always #2 clock = ~clock;

  // Sub-clock at a sixteenth of the system rate
  always @(posedge clock)
  begin
    sc_div <= sc_div + 4'h1;
    cycles <= cycles + 1;
    if (cycles == 22000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    @(posedge clock);
    while (rsp.pready !== 1'b1)
      @(posedge clock);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk(q, exp);
  endtask

  task automatic pulse(input logic h);
    halt <= h;
    clr <= !h;
    @(posedge clock);
    halt <= 1'b0;
    clr <= 1'b0;
    @(posedge clock);
  endtask

  // Equal bounds mean no pulse may appear before the bound
  task automatic expect_pulse(input logic sleep, input int lo, input int hi);
    int n;
    n = 0;
    while ((sleep ? pc_rst : dev_rst) !== 1'b1 && n < hi)
    begin
      @(posedge clock);
      n++;
    end
    chk(32'(n >= lo && (n < hi || lo == hi)), 32'h0000_0001);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
  endtask

  initial
  begin
    do_reset();
    rd(OFF_WDT_CTRL, 32'h0000_0053);
    rd(OFF_SYS_FLAGS, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    apb(OFF_WDT_CTRL, 1'b1, 32'h0000_0050);
    rd(OFF_WDT_CTRL, 32'h0000_0050);
    apb(OFF_IRQ_MASK, 1'b1, 32'h0000_0003);
    pulse(1'b0);
    expect_pulse(1'b0, 1015, 1035);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0000_0001);
    rd(OFF_STATUS, 32'h0000_0001);
    apb(OFF_IRQ_STAT, 1'b1, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk(32'(irq), 32'h0000_0000);
    pulse(1'b0);
    repeat (600) @(posedge clock);
    pulse(1'b1);
    rd(OFF_STATUS, 32'h0000_0002);
    expect_pulse(1'b0, 1005, 1035);
    pulse(1'b0);
    rd(OFF_STATUS, 32'h0000_0001);
    lpm <= 1'b1;
    repeat (600) @(posedge clock);
    pulse(1'b0);
    expect_pulse(1'b1, 1015, 1035);
    lpm <= 1'b0;
    apb(OFF_WDT_CTRL, 1'b1, 32'h0000_00A8);
    pulse(1'b0);
    expect_pulse(1'b0, 1100, 1100);
    apb(OFF_CONFIG, 1'b1, 32'h0000_0001);
    pulse(1'b0);
    expect_pulse(1'b0, 1015, 1035);
    // Build up a count so that only the key-fault reset can clear it
    repeat (600) @(posedge clock);
    apb(OFF_WDT_CTRL, 1'b1, 32'h0000_0000);
    expect_pulse(1'b0, 10, 60);
    rd(OFF_SYS_FLAGS, 32'h0000_0001);
    rd(OFF_WDT_CTRL, 32'h0000_0053);
    rd(OFF_IRQ_STAT, 32'h0000_0003);
    apb(OFF_WDT_CTRL, 1'b1, 32'h0000_0050);
    expect_pulse(1'b0, 995, 1030);
    rd(OFF_SYS_FLAGS, 32'h0000_0001);
    apb(OFF_SYS_FLAGS, 1'b1, 32'h0000_0000);
    rd(OFF_SYS_FLAGS, 32'h0000_0000);
    apb(OFF_CONFIG, 1'b1, 32'h0000_0003);
    pulse(1'b0);
    expect_pulse(1'b0, 4070, 4110);
    apb(OFF_CONFIG, 1'b1, 32'h0000_0001);
    apb(OFF_WDT_CTRL, 1'b1, 32'h0000_0051);
    stop <= 1'b1;
    pulse(1'b0);
    expect_pulse(1'b0, 1100, 1100);
    stop <= 1'b0;
    expect_pulse(1'b0, 4085, 4110);
    do_reset();
    chk(32'(dev_rst | pc_rst | irq), 32'h0000_0000);
    wrap_up();
  end
endmodule
